// *** verilog/sfd_pkg.sv ***
// constants, types and the parameter table for the discoverable-parameter read block
`default_nettype none

package sfd_pkg;

	localparam int unsigned SFD_MCLK_HZ      = 25_000_000;
	localparam logic [7:0]  SFD_OPCODE      = 8'h5a;
	localparam logic [4:0]  SFD_CMD_LAST    = 5'h07;
	localparam logic [4:0]  SFD_ADDR_LAST   = 5'h17;
	localparam logic [4:0]  SFD_DUMMY_LAST  = 5'h07;
	localparam logic [2:0]  SFD_BIT_LAST    = 3'h7;
	localparam int unsigned SFD_TABLE_AW    = 5;
	localparam int unsigned SFD_TABLE_DEPTH = 32;
	localparam int unsigned SFD_FIFO_WIDTH  = 8;
	localparam int unsigned SFD_FIFO_DEPTH  = 8;
	localparam logic [7:0]  SFD_VENDOR_SLOT = 8'h10;
	localparam logic [4:0]  SFD_ADDR_RESET  = 5'h00;
	localparam logic [7:0]  SFD_BYTE_RESET  = 8'h00;

	// header part of the table; the vendor slot is patched in by sfd_table_byte
	localparam logic [7:0] SFD_TABLE [0:SFD_TABLE_DEPTH-1] = '{
		8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h02, 8'hff,
		8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hff,
		8'h00, 8'h00, 8'h01, 8'h04, 8'h10, 8'h01, 8'h00, 8'hff,
		8'h84, 8'h00, 8'h01, 8'h02, 8'hc0, 8'h00, 8'h00, 8'hff
	};

	typedef enum logic [2:0] {
		ST_CMD,
		ST_ADDR,
		ST_DUMMY,
		ST_DATA,
		ST_IGNORE
	} sfd_state_t;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic di;
	} sfd_pins_t;

	typedef struct packed {
		logic [SFD_FIFO_WIDTH-1:0] data;
		logic                      valid;
	} sfd_word_t;

	function automatic logic [7:0] sfd_table_byte(input logic [4:0] idx, input logic [7:0] vendor);
		logic [7:0] b;
		b = SFD_TABLE[idx];
		if ({3'h0, idx} == SFD_VENDOR_SLOT) begin
			b = vendor;
		end
		return b;
	endfunction : sfd_table_byte

	function automatic logic [4:0] sfd_next_addr(input logic [4:0] a);
		return 5'(a + 5'h01);
	endfunction : sfd_next_addr

endpackage : sfd_pkg

`default_nettype wire

// *** verilog/sfd_fifo.sv ***
// small synchronous fifo with valid/ready on both sides and a flush
`default_nettype none

module sfd_fifo
	import sfd_pkg::*;
#(
	parameter int unsigned WIDTH = SFD_FIFO_WIDTH,
	parameter int unsigned DEPTH = SFD_FIFO_DEPTH
) (
	input  wire logic             mclk_in,
	input  wire logic             rst_in,
	input  wire logic             flush_in,
	input  wire logic             wr_valid_in,
	input  wire logic [WIDTH-1:0] wr_data_in,
	output logic                  wr_ready_out,
	output logic                  rd_valid_out,
	output logic      [WIDTH-1:0] rd_data_out,
	input  wire logic             rd_ready_in
);

	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [PW-1:0]    wr_ptr;
	logic [PW-1:0]    rd_ptr;
	logic [PW:0]      count;
	logic [PW-1:0]    next_wr_ptr;
	logic [PW-1:0]    next_rd_ptr;
	logic [PW:0]      next_count;
	logic             do_wr;
	logic             do_rd;

	assign wr_ready_out = (count != (PW+1)'(DEPTH));
	assign rd_valid_out = (count != '0);
	assign rd_data_out  = mem[rd_ptr];
	assign do_wr        = wr_valid_in && wr_ready_out && !flush_in;
	assign do_rd        = rd_valid_out && rd_ready_in && !flush_in;

	always_comb begin
		next_wr_ptr = do_wr ? PW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = do_rd ? PW'(rd_ptr + 1'b1) : rd_ptr;
		next_count  = (PW+1)'(count + (PW+1)'(do_wr) - (PW+1)'(do_rd));
		if (flush_in) begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count  = '0;
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// storage needs no reset: a word is only read after it was written
	always_ff @(posedge mclk_in) begin
		if (do_wr) begin
			mem[wr_ptr] <= wr_data_in;
		end
	end

endmodule : sfd_fifo

`default_nettype wire

// *** verilog/sfd_sfdp_read.sv ***
// device-side serial engine for the discoverable-parameter read command
// Behaviour
// - after the dummy byte, table data leaves on the output, changing on falling edges
// - any start address accepted; byte address advances by one per output byte
// - past the top table location the address wraps to zero and streaming continues
// - select high ends the command at any time; output drive stops, transfer abandoned
// - command arriving during erase, program or write is ignored, cycle untouched
// - bytes 00h-03h return 53h 46h 44h 50h, the signature
// - byte 04h returns minor revision 06h, byte 05h major revision 01h
// - byte 06h returns header count 02h, byte 07h returns FFh
// - first header: 00h 06h 01h 10h, pointer 000030h, FFh
// - second header: vendor byte, 00h 01h 04h, pointer bytes 10h 01h 00h, FFh
// - third header: 84h 00h 01h 02h, pointer bytes C0h 00h 00h, FFh
// - busy means the write-in-progress flag is 1 during erase or program
`default_nettype none

module sfd_sfdp_read
	import sfd_pkg::*;
#(
	parameter logic [7:0] VENDOR_ID = 8'h5c // arbitrary value
) (
	input  wire logic      mclk_in,
	input  wire logic      rst_in,
	input  wire sfd_pins_t pins_in,
	input  wire logic      write_in_progress_in,
	output logic           dout_out,
	output logic           dout_oe_out
);

	sfd_state_t state;
	sfd_state_t next_state;
	logic [4:0]  cnt;
	logic [4:0]  next_cnt;
	logic [23:0] shin;
	logic [23:0] next_shin;
	logic [4:0]  fetch_addr;
	logic [4:0]  next_fetch_addr;
	logic [7:0]  shout;
	logic [7:0]  next_shout;
	logic [2:0]  bcnt;
	logic [2:0]  next_bcnt;
	logic        dout;
	logic        next_dout;
	logic        dout_oe;
	logic        next_dout_oe;
	logic        sclk_prev;

	logic        rise;
	logic        fall;
	logic        push;
	logic        push_ready;
	logic [7:0]  push_data;
	sfd_word_t   head;
	logic        pop;
	logic        cmd_done;
	logic        load;

	assign rise      = pins_in.sclk && !sclk_prev;
	assign fall      = !pins_in.sclk && sclk_prev;
	assign cmd_done  = (state == ST_CMD) && rise && (cnt == SFD_CMD_LAST);
	assign push_data = sfd_table_byte(fetch_addr, VENDOR_ID);
	// prefetch starts once the address is known, so the fifo is full long before the first data fall
	assign push      = !pins_in.cs_n && ((state == ST_DUMMY) || (state == ST_DATA)) && push_ready;
	// a fall seen together with select high must not pop: the transfer is already being abandoned
	assign load      = !pins_in.cs_n && (state == ST_DATA) && fall && (bcnt == '0);
	assign pop       = load && head.valid;

	sfd_fifo #(
		.WIDTH (SFD_FIFO_WIDTH),
		.DEPTH (SFD_FIFO_DEPTH)
	) u_fifo (
		.mclk_in      (mclk_in),
		.rst_in       (rst_in),
		.flush_in     (pins_in.cs_n),
		.wr_valid_in  (push),
		.wr_data_in   (push_data),
		.wr_ready_out (push_ready),
		.rd_valid_out (head.valid),
		.rd_data_out  (head.data),
		.rd_ready_in  (pop)
	);

	always_comb begin
		next_state      = state;
		next_cnt        = cnt;
		next_shin       = shin;
		next_fetch_addr = fetch_addr;
		next_shout      = shout;
		next_bcnt       = bcnt;
		next_dout       = dout;
		next_dout_oe    = dout_oe;
		if (pins_in.cs_n) begin
			next_state   = ST_CMD;
			next_cnt     = '0;
			next_bcnt    = '0;
			next_dout_oe = 1'b0;
		end else begin
			case (state)
				ST_CMD: begin
					if (rise) begin
						next_shin = {shin[22:0], pins_in.di};
						next_cnt  = 5'(cnt + 5'h01);
						if (cnt == SFD_CMD_LAST) begin
							next_cnt = '0;
							// busy is sampled as the flag level when the opcode completes
							if ({shin[6:0], pins_in.di} != SFD_OPCODE || write_in_progress_in) begin
								next_state = ST_IGNORE;
							end else begin
								next_state = ST_ADDR;
							end
						end
					end
				end
				ST_ADDR: begin
					if (rise) begin
						next_shin = {shin[22:0], pins_in.di};
						next_cnt  = 5'(cnt + 5'h01);
						if (cnt == SFD_ADDR_LAST) begin
							next_cnt        = '0;
							// upper address bits fold onto the table size
							next_fetch_addr = {shin[3:0], pins_in.di};
							next_state      = ST_DUMMY;
						end
					end
				end
				ST_DUMMY: begin
					if (rise) begin
						next_cnt = 5'(cnt + 5'h01);
						if (cnt == SFD_DUMMY_LAST) begin
							next_cnt   = '0;
							next_state = ST_DATA;
						end
					end
				end
				ST_DATA: begin
					if (pop) begin
						next_dout    = head.data[7];
						next_shout   = {head.data[6:0], 1'b0};
						next_bcnt    = SFD_BIT_LAST;
						next_dout_oe = 1'b1;
					end else if (fall && bcnt != '0) begin
						next_dout  = shout[7];
						next_shout = {shout[6:0], 1'b0};
						next_bcnt  = 3'(bcnt - 3'h1);
					end
				end
				ST_IGNORE: begin
					next_dout_oe = 1'b0;
				end
				default: begin
					next_state = ST_CMD;
				end
			endcase
		end
		if (push) begin
			next_fetch_addr = sfd_next_addr(fetch_addr);
		end
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			state      <= ST_CMD;
			cnt        <= '0;
			shin       <= '0;
			fetch_addr <= SFD_ADDR_RESET;
			shout      <= SFD_BYTE_RESET;
			bcnt       <= '0;
			dout       <= 1'b0;
			dout_oe    <= 1'b0;
			sclk_prev  <= 1'b0;
		end else begin
			state      <= next_state;
			cnt        <= next_cnt;
			shin       <= next_shin;
			fetch_addr <= next_fetch_addr;
			shout      <= next_shout;
			bcnt       <= next_bcnt;
			dout       <= next_dout;
			dout_oe    <= next_dout_oe;
			sclk_prev  <= pins_in.sclk;
		end
	end

	assign dout_out    = dout;
	assign dout_oe_out = dout_oe;

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (rst_in);

	AST_CS_HIGH_STOPS: assert property (pins_in.cs_n |=> !dout_oe_out)
		else $error("output still driven after select went high");
	AST_DOUT_ON_FALL: assert property ($changed(dout_out) |-> $past(fall) && $past(state == ST_DATA))
		else $error("data output changed outside a falling edge in data phase");
	AST_MSB_FIRST: assert property (pop |=> dout_out == $past(head.data[7]) && dout_oe_out)
		else $error("first bit of a byte is not its top bit");
	AST_DUMMY_EIGHT: assert property ((state == ST_DUMMY) && rise && (cnt == SFD_DUMMY_LAST) && !pins_in.cs_n
		|=> state == ST_DATA)
		else $error("data phase not entered after eight dummy clocks");
	AST_BUSY_IGNORED: assert property (cmd_done && write_in_progress_in && !pins_in.cs_n
		|=> state == ST_IGNORE ##1 !dout_oe_out)
		else $error("command not ignored while busy");
	AST_IDLE_ACCEPTED: assert property (cmd_done && !write_in_progress_in && !pins_in.cs_n
		&& ({shin[6:0], pins_in.di} == 8'h5a) |=> state == ST_ADDR)
		else $error("command refused although not busy");
	AST_ADDR_STEP: assert property (push && !$past(pins_in.cs_n) |=> fetch_addr == 5'($past(fetch_addr) + 5'h01))
		else $error("byte address did not advance by one");
	AST_ADDR_WRAP: assert property (push && fetch_addr == 5'h1f |=> fetch_addr == 5'h00)
		else $error("byte address did not wrap to zero");
	AST_SIGNATURE: assert property (push && fetch_addr == 5'h00 |-> push_data == 8'h53)
		else $error("signature byte wrong");
	AST_MINOR_REV: assert property (push && fetch_addr == 5'h04 |-> push_data == 8'h06)
		else $error("minor revision wrong");
	AST_HDR_COUNT: assert property (push && fetch_addr == 5'h06 |-> push_data == 8'h02)
		else $error("header count wrong");
	AST_HDR1_LEN: assert property (push && fetch_addr == 5'h0b |-> push_data == 8'h10)
		else $error("first header length wrong");
	AST_HDR2_LEN: assert property (push && fetch_addr == 5'h13 |-> push_data == 8'h04)
		else $error("second header length wrong");
	AST_HDR3_ID: assert property (push && fetch_addr == 5'h18 |-> push_data == 8'h84)
		else $error("third header id wrong");

	COV_DATA_BYTE: cover property (pop ##[1:200] pop);
	COV_BUSY_REJECT: cover property (cmd_done && write_in_progress_in);
	COV_WRAP: cover property (push && fetch_addr == 5'h1f);
	COV_ABORT_IN_DATA: cover property ((state == ST_DATA) && dout_oe_out ##1 pins_in.cs_n);

endmodule : sfd_sfdp_read

`default_nettype wire

// *** verification/sfd_host_model.sv ***
// host controller model that drives the serial pins of the parameter read block
`default_nettype none

module sfd_host_model
	import sfd_pkg::*;
(
	input  wire logic      mclk_in,
	input  wire logic      dout_in,
	output var  sfd_pins_t pins_out
);
	timeunit 1ns;
	timeprecision 1ns;

	initial pins_out = '{cs_n: 1'b1, sclk: 1'b0, di: 1'b0};

	// four mclk per clock level; the device needs at least two
	task automatic bit_io(input logic d, output logic q);
		pins_out.di   <= d;
		pins_out.sclk <= 1'b0;
		repeat (4) @(posedge mclk_in);
		q = dout_in;
		pins_out.sclk <= 1'b1;
		repeat (4) @(posedge mclk_in);
	endtask : bit_io

	task automatic xfer(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
	endtask : xfer

	task automatic start(input logic [7:0] op, input logic [23:0] a);
		logic [7:0] junk;
		pins_out.cs_n <= 1'b0;
		xfer(op, junk);
		xfer(a[23:16], junk);
		xfer(a[15:8], junk);
		xfer(a[7:0], junk);
		xfer(8'ha5, junk);
	endtask : start

	// select rises with the clock falling; the data line flips so nothing stale lingers
	task automatic stop();
		repeat (2) @(posedge mclk_in);
		pins_out.cs_n <= 1'b1;
		pins_out.sclk <= 1'b0;
		pins_out.di   <= ~pins_out.di;
		repeat (4) @(posedge mclk_in);
	endtask : stop
endmodule : sfd_host_model

`default_nettype wire

// *** verification/sfd_sfdp_read_tb.sv ***
// self-checking bench for the parameter read block and its prefetch fifo
`default_nettype none

module sfd_sfdp_read_tb
	import sfd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [7:0] VENDOR = 8'ha7; // arbitrary value

	logic       mclk_in  = 1'b0;
	logic       rst_in   = 1'b1;
	logic       write_in_progress      = 1'b0;
	logic       dout;
	logic       oe;
	sfd_pins_t  pins;
	int         bad_count = 0;
	int         checked   = 0;
	logic [7:0] exp_tab [0:31] = '{
		8'h53, 8'h46, 8'h44, 8'h50, 8'h06, 8'h01, 8'h02, 8'hff,
		8'h00, 8'h06, 8'h01, 8'h10, 8'h30, 8'h00, 8'h00, 8'hff,
		VENDOR, 8'h00, 8'h01, 8'h04, 8'h10, 8'h01, 8'h00, 8'hff,
		8'h84, 8'h00, 8'h01, 8'h02, 8'hc0, 8'h00, 8'h00, 8'hff
	};

	always #20 mclk_in = ~mclk_in;

	sfd_sfdp_read #(.VENDOR_ID(VENDOR)) sfd_sfdp_read_i (
		.mclk_in(mclk_in), .rst_in(rst_in), .pins_in(pins),
		.write_in_progress_in(write_in_progress), .dout_out(dout), .dout_oe_out(oe)
	);

	// an undriven data line shows the inverse of the held value, so a missing enable cannot pass unseen
	sfd_host_model sfd_host_model_i (.mclk_in(mclk_in), .dout_in(oe ? dout : !dout), .pins_out(pins));

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic rd(input logic [4:0] a, input int n);
		logic [7:0] q;
		for (int i = 0; i < n; i++) begin
			sfd_host_model_i.xfer(8'h00, q);
			chk("table byte", exp_tab[5'(a + 5'(i))], q);
			chk("output enable", 8'h01, {7'h0, oe});
		end
	endtask : rd

	task automatic stop_read();
		sfd_host_model_i.stop();
		chk("enable after select high", 8'h00, {7'h0, oe});
	endtask : stop_read

	task automatic t_full();
		sfd_host_model_i.start(8'h5a, 24'h000000);
		rd(5'h00, 34);
		stop_read();
	endtask : t_full

	// upper address bits set, start just below the top so the wrap comes early
	task automatic t_high();
		sfd_host_model_i.start(8'h5a, 24'hc3a51e);
		rd(5'h1e, 3);
		stop_read();
	endtask : t_high

	task automatic t_abort();
		logic [2:0] q;
		sfd_host_model_i.start(8'h5a, 24'h000007);
		for (int i = 2; i >= 0; i--) sfd_host_model_i.bit_io(1'b0, q[i]);
		chk("partial byte", 8'h07, {5'h0, q});
		stop_read();
		sfd_host_model_i.start(8'h5a, 24'h000006);
		rd(5'h06, 2);
		stop_read();
	endtask : t_abort

	task automatic t_refused(input logic busy, input logic [7:0] op);
		logic [7:0] q;
		write_in_progress <= busy;
		sfd_host_model_i.start(op, 24'h000000);
		for (int i = 0; i < 2; i++) begin
			sfd_host_model_i.xfer(8'h00, q);
			chk("enable while refused", 8'h00, {7'h0, oe});
		end
		sfd_host_model_i.stop();
		write_in_progress <= 1'b0;
		sfd_host_model_i.start(8'h5a, 24'h000000);
		rd(5'h00, 1);
		stop_read();
	endtask : t_refused

	// a read longer than the prefetch store makes it drain and refill; the restart after select high
	// must not replay words left over from the abandoned read
	task automatic t_fifo();
		logic [7:0] q;
		sfd_host_model_i.start(8'h5a, 24'h00000c);
		rd(5'h0c, 12);
		sfd_host_model_i.xfer(8'h00, q);
		chk("byte after refills", exp_tab[5'h18], q);
		chk("enable after refills", 8'h01, {7'h0, oe});
		stop_read();
		sfd_host_model_i.start(8'h5a, 24'h000010);
		sfd_host_model_i.xfer(8'h00, q);
		chk("first byte after flush", VENDOR, q);
		chk("enable after flush", 8'h01, {7'h0, oe});
		rd(5'h11, 2);
		stop_read();
	endtask : t_fifo

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	initial begin
		repeat (100000) @(posedge mclk_in);
		bad_count++;
		stop_test();
	end

	initial begin
		repeat (16) @(posedge mclk_in);
		rst_in <= 1'b0;
		repeat (4) @(posedge mclk_in);
		t_full();
		t_high();
		t_abort();
		t_refused(1'b1, 8'h5a);
		t_refused(1'b0, 8'h03);
		t_fifo();
		stop_test();
	end
endmodule : sfd_sfdp_read_tb

`default_nettype wire
